// ==== vtc_pkg.sv ====
// vtc_pkg: constants for the timing and chroma register bank of one decoder channel.
// assumes the serial-bus front end delivers byte-wide register reads and writes.

package vtc_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] VTC_ADDR_WINDOW = 8'h17; // window code inclusion, scaler power
	localparam logic [7:0] VTC_ADDR_VB_START = 8'h18; // vertical blank start offset
	localparam logic [7:0] VTC_ADDR_VB_STOP = 8'h19; // vertical blank stop offset
	localparam logic [7:0] VTC_ADDR_CHROMA1 = 8'h1A; // chroma control one
	localparam logic [7:0] VTC_ADDR_CHROMA2 = 8'h1B; // chroma control two
	localparam logic [7:0] VTC_ADDR_INTB_CLR = 8'h1C; // interrupt b status clear

	// ************************************************************
	// reset values and writable masks
	// ************************************************************
	localparam logic [7:0] VTC_RST_WINDOW = 8'h52;
	localparam logic [7:0] VTC_RST_VB_START = 8'h00;
	localparam logic [7:0] VTC_RST_VB_STOP = 8'h00;
	localparam logic [7:0] VTC_RST_CHROMA1 = 8'h0C;
	localparam logic [7:0] VTC_RST_CHROMA2 = 8'h14;
	localparam logic [7:0] VTC_MASK_WINDOW = 8'h7F; // bit 7 reserved
	localparam logic [7:0] VTC_MASK_CHROMA1 = 8'h1F; // bits 7:5 reserved
	localparam logic [7:0] VTC_MASK_CHROMA2 = 8'h07; // bits 7:3 reserved
	localparam logic [7:0] VTC_FIXED_CHROMA2 = 8'h10; // reserved bit 4 reads one
	localparam logic [7:0] VTC_MASK_INTB = 8'h9F; // bits 6:5 reserved

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int VTC_BIT_UNS_EAV = 0;
	localparam int VTC_BIT_UNS_SAV = 1;
	localparam int VTC_BIT_UNS_ANC = 2;
	localparam int VTC_BIT_SCL_EAV = 3;
	localparam int VTC_BIT_SCL_SAV = 4;
	localparam int VTC_BIT_SCL_ANC = 5;
	localparam int VTC_BIT_SCALER_POWER_DOWN = 6;
	localparam int VTC_BIT_PLL_RST = 4;
	localparam int VTC_BIT_ACE = 3;
	localparam int VTC_BIT_CE = 2;
	localparam int VTC_BIT_WCF = 2;
	localparam int VTC_BIT_TAPE_CHG = 0;

	// ************************************************************
	// auto colour gain codes
	// ************************************************************
	localparam logic [1:0] VTC_ACG_ON = 2'h0;
	localparam logic [1:0] VTC_ACG_OFF = 2'h2;
	localparam logic [1:0] VTC_ACG_FREEZE = 2'h3;

	// ************************************************************
	// chroma output bandwidth, in units of 100 hz
	// ************************************************************
	localparam logic [13:0] VTC_BW_N0 = 14'd12214;
	localparam logic [13:0] VTC_BW_N1 = 14'd8782;
	localparam logic [13:0] VTC_BW_N2 = 14'd7297;
	localparam logic [13:0] VTC_BW_N3 = 14'd4986;
	localparam logic [13:0] VTC_BW_W0 = 14'd14170;
	localparam logic [13:0] VTC_BW_W1 = 14'd10303;
	localparam logic [13:0] VTC_BW_W2 = 14'd8438;
	localparam logic [13:0] VTC_BW_W3 = 14'd5537;

endpackage

// ==== vtc_regs.sv ====
// vtc_regs: timing and chroma control registers of one decoder channel, with the
// vertical blank window, tape mode detector and interrupt b status bits.
// assumes the serial-bus front end and the video timing run on clk_i.
//
// Function
// R1 - eav code excluded unless include bit set
// R2 - sav code included unless include bit cleared
// R3 - ancillary region kept unless exclude bit set
// R4 - scaler power-down bit six, set at reset
// R5 - blank start is signed line offset
// R6 - blank stop is signed line offset
// R7 - vertical blank output timed from adjusted offsets
// R8 - luma bypass bounded by same adjusted window
// R9 - pll reset write pulses pll, genlock bit
// R10 - adaptive comb enable, on at reset
// R11 - comb enable, on at reset
// R12 - auto colour gain: on, off, frozen
// R13 - chroma filter select: no notch, notch 1-3
// R14 - wide filter and select set bandwidth
// R15 - host writes one to clear status
// R16 - clear bits map to six status bits
// R17 - tape mode from nonstandard lines per frame
// R18 - status sets regardless of enable mask
// R19 - reserved bits read zero except chroma two bit 4, which reads one, writes ignored

`timescale 1ns/1ps
`default_nettype none

module vtc_regs #(
	parameter int LINE_W = 10 // width of line numbers and counts
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	// register port from the serial-bus front end
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// video timing from the decoder core
	input wire logic line_start_i,
	input wire logic frame_start_i,
	input wire logic [LINE_W-1:0] line_num_i,
	input wire logic [LINE_W-1:0] std_vblank_start_i,
	input wire logic [LINE_W-1:0] std_vblank_stop_i,
	input wire logic [LINE_W-1:0] std_lines_per_frame_i,
	input wire logic vblank_pin_sel_i,
	input wire logic [7:0] intb_event_i,
	input wire logic genlock_reset_sent_i,
	// decoded controls
	output logic unscaled_eav_incl_o,
	output logic unscaled_sav_incl_o,
	output logic unscaled_anc_excl_o,
	output logic scaled_eav_incl_o,
	output logic scaled_sav_incl_o,
	output logic scaled_anc_excl_o,
	output logic scaler_power_down_o,
	output logic vertical_blank_output_o,
	output logic luma_bypass_window_o,
	output logic color_pll_reset_o,
	output logic genlock_reset_bit_o,
	output logic adaptive_comb_enable_o,
	output logic comb_enable_o,
	output logic [1:0] auto_color_gain_mode_o,
	output logic auto_gain_enable_o,
	output logic auto_gain_freeze_o,
	output logic wide_chroma_filter_o,
	output logic [1:0] chroma_filter_sel_o,
	output logic [13:0] chroma_bw_o,
	output logic broadcast_vs_tape_mode_o,
	output logic [7:0] intb_status_o
);
	import vtc_pkg::*;

	// refuse line widths that the sign extension and the counters cannot serve
	if (LINE_W < 9 || LINE_W > 16) begin : g_bad_line_w
		$error("vtc_regs: LINE_W must lie in 9..16");
	end

	// ************************************************************
	// register file
	// ************************************************************
	logic [7:0] window_r, window_nxt; // code inclusion and scaler power
	logic [7:0] vb_start_r, vb_start_nxt; // signed start offset
	logic [7:0] vb_stop_r, vb_stop_nxt; // signed stop offset
	logic [7:0] chroma1_r, chroma1_nxt; // chroma control one
	logic [7:0] chroma2_r, chroma2_nxt; // chroma control two
	logic [7:0] rdata_r, rdata_nxt; // read data
	logic pll_rst_r, pll_rst_nxt; // one-cycle colour pll reset
	logic genlock_control_output_rst_r, genlock_control_output_rst_nxt; // pending genlock reset bit
	logic [13:0] bw_r, bw_nxt; // chroma bandwidth

	// next values of the register file
	always_comb begin
		window_nxt = window_r;
		vb_start_nxt = vb_start_r;
		vb_stop_nxt = vb_stop_r;
		chroma1_nxt = chroma1_r;
		chroma2_nxt = chroma2_r;
		// the pll reset is a pulse, low unless written again
		pll_rst_nxt = 1'b0;
		genlock_control_output_rst_nxt = genlock_control_output_rst_r;
		// sent bit leaves the stream, a new write wins
		if (genlock_reset_sent_i) begin
			genlock_control_output_rst_nxt = 1'b0;
		end
		if (reg_wr_i) begin
			case (reg_addr_i)
				// reserved bits are masked off
				VTC_ADDR_WINDOW: begin
					window_nxt = reg_wdata_i & VTC_MASK_WINDOW; // R1 R2 R3 R4 R19
				end
				VTC_ADDR_VB_START: begin
					vb_start_nxt = reg_wdata_i; // R5
				end
				VTC_ADDR_VB_STOP: begin
					vb_stop_nxt = reg_wdata_i; // R6
				end
				VTC_ADDR_CHROMA1: begin
					chroma1_nxt = reg_wdata_i & VTC_MASK_CHROMA1; // R19
					if (reg_wdata_i[VTC_BIT_PLL_RST]) begin
						pll_rst_nxt = 1'b1; // R9
						genlock_control_output_rst_nxt = 1'b1; // R9
					end
				end
				VTC_ADDR_CHROMA2: begin
					chroma2_nxt = reg_wdata_i & VTC_MASK_CHROMA2; // R19
				end
				default: begin
				end
			endcase
		end
		// bandwidth from wide flag and filter select
		// registered, so the output trails the register by one cycle
		case ({chroma2_r[VTC_BIT_WCF], chroma2_r[1:0]})
			3'h0: bw_nxt = VTC_BW_N0; // R14
			3'h1: bw_nxt = VTC_BW_N1;
			3'h2: bw_nxt = VTC_BW_N2;
			3'h3: bw_nxt = VTC_BW_N3;
			3'h4: bw_nxt = VTC_BW_W0;
			3'h5: bw_nxt = VTC_BW_W1;
			3'h6: bw_nxt = VTC_BW_W2;
			default: bw_nxt = VTC_BW_W3;
		endcase
		// read mux, clear register and unmapped read as zero
		// the answer stands one cycle after the address
		case (reg_addr_i)
			VTC_ADDR_WINDOW: rdata_nxt = window_r;
			VTC_ADDR_VB_START: rdata_nxt = vb_start_r;
			VTC_ADDR_VB_STOP: rdata_nxt = vb_stop_r;
			VTC_ADDR_CHROMA1: rdata_nxt = chroma1_r;
			VTC_ADDR_CHROMA2: rdata_nxt = chroma2_r | VTC_FIXED_CHROMA2;
			default: rdata_nxt = 8'h00; // R19
		endcase
	end

	// register the file
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			window_r <= VTC_RST_WINDOW;
			vb_start_r <= VTC_RST_VB_START;
			vb_stop_r <= VTC_RST_VB_STOP;
			chroma1_r <= VTC_RST_CHROMA1;
			chroma2_r <= VTC_RST_CHROMA2 & VTC_MASK_CHROMA2;
			rdata_r <= 8'h00;
			pll_rst_r <= 1'b0;
			genlock_control_output_rst_r <= 1'b0;
			bw_r <= VTC_BW_W0;
		end else begin
			window_r <= window_nxt;
			vb_start_r <= vb_start_nxt;
			vb_stop_r <= vb_stop_nxt;
			chroma1_r <= chroma1_nxt;
			chroma2_r <= chroma2_nxt;
			rdata_r <= rdata_nxt;
			pll_rst_r <= pll_rst_nxt;
			genlock_control_output_rst_r <= genlock_control_output_rst_nxt;
			bw_r <= bw_nxt;
		end
	end

	// ************************************************************
	// vertical blank window
	// ************************************************************
	logic [LINE_W-1:0] adj_start; // standard start moved by offset
	logic [LINE_W-1:0] adj_stop; // standard stop moved by offset
	logic vblank_r, vblank_nxt; // window level

	// signed offsets, wrap within the line number width
	// an offset of 80h moves the edge 128 lines earlier
	assign adj_start = LINE_W'(std_vblank_start_i + {{(LINE_W-8){vb_start_r[7]}}, vb_start_r}); // R5
	assign adj_stop = LINE_W'(std_vblank_stop_i + {{(LINE_W-8){vb_stop_r[7]}}, vb_stop_r}); // R6

	// window opens on the adjusted start line, closes on the adjusted stop line
	// a stop line equal to the start line keeps the window shut
	always_comb begin
		vblank_nxt = vblank_r;
		if (line_start_i) begin
			if (line_num_i == adj_stop) begin
				vblank_nxt = 1'b0; // R7 R8
			end else if (line_num_i == adj_start) begin
				vblank_nxt = 1'b1; // R7 R8
			end
		end
	end

	// register the window
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vblank_r <= 1'b0;
		end else begin
			vblank_r <= vblank_nxt;
		end
	end

	// ************************************************************
	// tape mode detector and interrupt b status
	// ************************************************************
	logic [LINE_W-1:0] line_cnt_r, line_cnt_nxt; // lines in current frame
	logic tape_r, tape_nxt; // broadcast or tape mode
	logic framed_r, framed_nxt; // a frame start has been seen since reset
	logic [7:0] status_r, status_nxt; // interrupt b status
	logic [7:0] events; // all status-setting events this cycle

	// count lines, judge the frame at its end
	always_comb begin
		line_cnt_nxt = line_cnt_r;
		tape_nxt = tape_r;
		framed_nxt = framed_r;
		if (frame_start_i) begin
			// the first frame after reset only starts the count, a partial
			// frame would raise a false tape mode and a false change event
			if (framed_r) begin
				// a short or long frame means tape
				tape_nxt = (line_cnt_r != std_lines_per_frame_i); // R17
			end
			framed_nxt = 1'b1;
			line_cnt_nxt = line_start_i ? LINE_W'(1) : '0;
		end else if (line_start_i) begin
			line_cnt_nxt = LINE_W'(line_cnt_r + 1'b1); // R17
		end
	end

	// status bits: set wins over a clear in the same cycle, no enable mask here
	always_comb begin
		events = intb_event_i;
		events[VTC_BIT_TAPE_CHG] = intb_event_i[VTC_BIT_TAPE_CHG] | (tape_nxt != tape_r);
		events = events & VTC_MASK_INTB; // R16
		status_nxt = status_r;
		// reserved bits never set, so clearing them changes nothing
		if (reg_wr_i && reg_addr_i == VTC_ADDR_INTB_CLR) begin
			status_nxt = status_r & ~reg_wdata_i; // R15 R16
		end
		status_nxt = status_nxt | events; // R18
	end

	// register detector and status
	// status bits hold until the host clears them
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			line_cnt_r <= '0;
			tape_r <= 1'b0;
			framed_r <= 1'b0;
			status_r <= 8'h00;
		end else begin
			line_cnt_r <= line_cnt_nxt;
			tape_r <= tape_nxt;
			framed_r <= framed_nxt;
			status_r <= status_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign reg_rdata_o = rdata_r;
	// window code inclusion and scaler power straight from the register
	assign unscaled_eav_incl_o = window_r[VTC_BIT_UNS_EAV]; // R1
	assign scaled_eav_incl_o = window_r[VTC_BIT_SCL_EAV]; // R1
	assign unscaled_sav_incl_o = window_r[VTC_BIT_UNS_SAV]; // R2
	assign scaled_sav_incl_o = window_r[VTC_BIT_SCL_SAV]; // R2
	assign unscaled_anc_excl_o = window_r[VTC_BIT_UNS_ANC]; // R3
	assign scaled_anc_excl_o = window_r[VTC_BIT_SCL_ANC]; // R3
	assign scaler_power_down_o = window_r[VTC_BIT_SCALER_POWER_DOWN]; // R4
	// blank window, shown on the shared pin only while it is selected
	assign vertical_blank_output_o = vblank_r & vblank_pin_sel_i; // R7
	assign luma_bypass_window_o = vblank_r; // R8
	assign color_pll_reset_o = pll_rst_r; // R9
	assign genlock_reset_bit_o = genlock_control_output_rst_r; // R9
	// chroma controls
	assign adaptive_comb_enable_o = chroma1_r[VTC_BIT_ACE]; // R10
	assign comb_enable_o = chroma1_r[VTC_BIT_CE]; // R11
	assign auto_color_gain_mode_o = chroma1_r[1:0];
	// reserved code 01 behaves as enabled
	assign auto_gain_enable_o = (chroma1_r[1:0] != VTC_ACG_OFF) && (chroma1_r[1:0] != VTC_ACG_FREEZE); // R12
	assign auto_gain_freeze_o = (chroma1_r[1:0] == VTC_ACG_FREEZE); // R12
	assign wide_chroma_filter_o = chroma2_r[VTC_BIT_WCF]; // R14
	assign chroma_filter_sel_o = chroma2_r[1:0]; // R13
	assign chroma_bw_o = bw_r; // R14
	assign broadcast_vs_tape_mode_o = tape_r; // R17
	assign intb_status_o = status_r;

endmodule

`default_nettype wire

// ==== vtc_host.sv ====
// vtc_host: host processor model that writes and reads single register bytes.
// assumes each call starts one small delay after a rising clk_i edge.
`timescale 1ns/1ps
`default_nettype none
module vtc_host (
	input wire logic clk_i,
	input wire logic [7:0] reg_rdata_i,
	output logic reg_wr_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o
);
	// ************************************************************
	// bus tasks
	// ************************************************************
	initial begin
		reg_wr_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'hFF;
	end
	// one strobe cycle, then an idle cycle; released data is inverted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge clk_i);
		#1 reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
		@(posedge clk_i);
		#1;
	endtask
	// read data answers one cycle after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr_o = a;
		@(posedge clk_i);
		#1 d = reg_rdata_i;
	endtask
	// status bits written one are cleared
	task automatic clr(input logic [7:0] m);
		wr(8'h1C, m);
	endtask
endmodule
`default_nettype wire

// ==== vtc_regs_chk.sv ====
// vtc_regs_chk: port assertions for the timing and chroma register bank.
// assumes it is bound into vtc_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module vtc_regs_chk (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] intb_event_i,
	input wire logic vblank_pin_sel_i,
	input wire logic scaler_power_down_o,
	input wire logic vertical_blank_output_o,
	input wire logic luma_bypass_window_o,
	input wire logic color_pll_reset_o,
	input wire logic genlock_reset_bit_o,
	input wire logic [1:0] auto_color_gain_mode_o,
	input wire logic auto_gain_enable_o,
	input wire logic auto_gain_freeze_o,
	input wire logic wide_chroma_filter_o,
	input wire logic [1:0] chroma_filter_sel_o,
	input wire logic [13:0] chroma_bw_o,
	input wire logic [7:0] intb_status_o
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire logic pll_wr = reg_wr_i && reg_addr_i == 8'h1A && reg_wdata_i[4]; // pll reset write
	wire logic clr_wr = reg_wr_i && reg_addr_i == 8'h1C; // status clear write
	property p_pll; pll_wr |=> color_pll_reset_o; endproperty
	a_pll: assert property (p_pll) else $error("pll reset pulse missing");
	property p_pll_cause; color_pll_reset_o |-> $past(pll_wr); endproperty
	a_pll_cause: assert property (p_pll_cause) else $error("pll pulse without write");
	property p_glk; pll_wr |=> genlock_reset_bit_o; endproperty
	a_glk: assert property (p_glk) else $error("genlock reset bit not set");
	property p_pd; reg_wr_i && reg_addr_i == 8'h17
		|=> scaler_power_down_o == $past(reg_wdata_i[6]); endproperty
	a_pd: assert property (p_pd) else $error("scaler power down wrong");
	property p_acg; auto_gain_freeze_o == (auto_color_gain_mode_o == 2'h3)
		&& auto_gain_enable_o == !auto_color_gain_mode_o[1]; endproperty
	a_acg: assert property (p_acg) else $error("auto gain decode wrong");
	property p_bw; wide_chroma_filter_o && chroma_filter_sel_o == 2'h3
		|=> chroma_bw_o == 14'd5537; endproperty
	a_bw: assert property (p_bw) else $error("wide notch three bandwidth wrong");
	property p_set; intb_event_i[3] |=> intb_status_o[3]; endproperty
	a_set: assert property (p_set) else $error("status bit not set");
	property p_clr; clr_wr && reg_wdata_i[2] && !intb_event_i[2] |=> !intb_status_o[2]; endproperty
	a_clr: assert property (p_clr) else $error("status bit not cleared");
	property p_keep; clr_wr && !reg_wdata_i[4] && intb_status_o[4] |=> intb_status_o[4]; endproperty
	a_keep: assert property (p_keep) else $error("status cleared by zero");
	property p_rsv; intb_status_o[6:5] == 2'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits set");
	property p_vb; vertical_blank_output_o == (luma_bypass_window_o && vblank_pin_sel_i); endproperty
	a_vb: assert property (p_vb) else $error("blank output differs from window");
endmodule
bind vtc_regs vtc_regs_chk u_chk (.*);
`default_nettype wire

// ==== testbench.sv ====
// testbench: self-checking bench for vtc_regs with a host model.
// assumes vtc_pkg and vtc_host are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import vtc_pkg::*;
	// ************************************************************
	// signals and model state
	// ************************************************************
	logic clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i, line_start_i = 1'b0, frame_start_i = 1'b0;
	logic vblank_pin_sel_i = 1'b0, genlock_reset_sent_i = 1'b0;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, intb_event_i = 8'h00, intb_status_o;
	logic [9:0] line_num_i = 10'h000, std_vblank_start_i = 10'd150, std_vblank_stop_i = 10'd40;
	logic [9:0] std_lines_per_frame_i = 10'd60;
	logic unscaled_eav_incl_o, unscaled_sav_incl_o, unscaled_anc_excl_o, scaled_eav_incl_o;
	logic scaled_sav_incl_o, scaled_anc_excl_o, scaler_power_down_o, vertical_blank_output_o;
	logic luma_bypass_window_o, color_pll_reset_o, genlock_reset_bit_o, adaptive_comb_enable_o;
	logic comb_enable_o, auto_gain_enable_o, auto_gain_freeze_o, wide_chroma_filter_o;
	logic broadcast_vs_tape_mode_o;
	logic [1:0] auto_color_gain_mode_o, chroma_filter_sel_o;
	logic [13:0] chroma_bw_o;
	int err_count = 0, samples_checked = 0, pll_cnt = 0;
	int bwt [0:7] = '{12214, 8782, 7297, 4986, 14170, 10303, 8438, 5537};
	int fl [0:4] = '{60, 60, 57, 60, 60};
	logic [31:0] seed = 32'd71;
	logic [7:0] m [0:4] = '{8'h52, 8'h00, 8'h00, 8'h0C, 8'h04};
	vtc_regs #(.LINE_W(10)) DUT (.*);
	vtc_host host (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) pll_cnt <= pll_cnt + int'(color_pll_reset_o);
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		if (a >= 8'h17 && a <= 8'h1A) return m[a - 8'h17];
		if (a == 8'h1B) return m[4] | VTC_FIXED_CHROMA2;
		return 8'h00;
	endfunction
	// model write, then the same byte through the host
	task automatic put(input logic [7:0] a, input logic [7:0] v);
		case (a)
			8'h17: m[0] = v & VTC_MASK_WINDOW;
			8'h18, 8'h19: m[a - 8'h17] = v;
			8'h1A: m[3] = v & VTC_MASK_CHROMA1;
			8'h1B: m[4] = v & VTC_MASK_CHROMA2;
			default: ;
		endcase
		host.wr(a, v);
	endtask
	task automatic chk_out();
		chk({m[0][6:0], m[3][3:0], !m[3][1], m[3][1:0] == 2'h3, m[4][2:0]},
			{scaler_power_down_o, scaled_anc_excl_o, scaled_sav_incl_o, scaled_eav_incl_o,
			unscaled_anc_excl_o, unscaled_sav_incl_o, unscaled_eav_incl_o,
			adaptive_comb_enable_o, comb_enable_o, auto_color_gain_mode_o,
			auto_gain_enable_o, auto_gain_freeze_o, wide_chroma_filter_o, chroma_filter_sel_o});
		chk(bwt[m[4][2:0]], chroma_bw_o);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		print_verdict();
	end
	initial begin
		logic [7:0] d, a;
		logic [31:0] r;
		logic [7:0] mst;
		int c, w;
		repeat (12) @(posedge clk_i);
		#1 nrst_i = 1'b1;
		for (int i = 8'h16; i <= 8'h1D; i++) begin
			host.rd(8'(i), d);
			chk(exp_rd(8'(i)), d);
		end
		chk_out();
		$display("test reset values done");
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			a = 8'h17 + 8'(r[15:8] % 7);
			put(a, r[7:0]);
			chk_out();
			host.rd(a, d);
			chk(exp_rd(a), d);
		end
		for (int i = 0; i < 8; i++) begin
			put(8'h1A, 8'h0C | 8'(i[1:0]));
			put(8'h1B, 8'(i));
			chk_out();
		end
		$display("test register fields done");
		genlock_reset_sent_i = 1'b1;
		cyc(1);
		genlock_reset_sent_i = 1'b0;
		chk(0, genlock_reset_bit_o);
		c = pll_cnt;
		put(8'h1A, 8'h1F);
		chk(c + 1, pll_cnt);
		chk(1, genlock_reset_bit_o);
		put(8'h1A, 8'h0F);
		chk(c + 1, pll_cnt);
		genlock_reset_sent_i = 1'b1;
		cyc(1);
		genlock_reset_sent_i = 1'b0;
		cyc(1);
		chk(0, genlock_reset_bit_o);
		$display("test pll reset done");
		mst = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			intb_event_i = r[7:0];
			cyc(1);
			intb_event_i = 8'h00;
			mst = mst | (r[7:0] & VTC_MASK_INTB);
			chk(mst, intb_status_o);
			intb_event_i = r[15:8];
			fork
				host.clr(r[23:16]);
				begin cyc(1); intb_event_i = 8'h00; end
			join
			mst = (mst & ~r[23:16] | r[15:8]) & VTC_MASK_INTB;
			chk(mst, intb_status_o);
		end
		$display("test interrupt status done");
		host.clr(8'hFF);
		chk(8'h00, intb_status_o);
		put(8'h18, 8'h80);
		put(8'h19, 8'hFF);
		w = 0;
		for (int k = 0; k < 5; k++) for (int n = 0; n < fl[k]; n++) begin
			r = rnd();
			line_num_i = 10'(n);
			line_start_i = 1'b1;
			frame_start_i = n == 0;
			vblank_pin_sel_i = r[0];
			cyc(1);
			line_start_i = 1'b0;
			frame_start_i = 1'b0;
			if (n == 150 + int'($signed(m[1]))) w = 1;
			if (n == 40 + int'($signed(m[2]))) w = 0;
			chk({w[0], w[0] & r[0]}, {luma_bypass_window_o, vertical_blank_output_o});
			if (n == 0) chk((k > 0) ? fl[k - 1] != 60 : 0, broadcast_vs_tape_mode_o);
			cyc(1);
		end
		chk(8'h01, intb_status_o);
		$display("test blank window and tape mode done");
		print_verdict();
	end
endmodule
`default_nettype wire
